// [src/pmlr_pkg.sv]
// What this block does
// - Thirty-two outgoing peer points each carry one separately selected internal operand.
// - Unchanged points are resent after a 1 to 60 s refresh interval, default 60 s.
// - Transport is GOOSE, GSSE or none, default GSSE; VLAN and APPID only for GOOSE.
// - A latched indicator stays set after its condition clears until a reset command.
// - A reset clears a latch only when that latch's condition has already cleared.
// - Reset commands touch only indicator and message latches, never user logic latches.
// - Button, comms or selected operand resets raise the common and a source operand.
// - Thirty-two direct outputs each follow one selected internal operand.
// - Each direct input takes the chosen bit from one configured source device.
// - Offline source with fallback On forces the direct input to logic 1.
// - Offline source with fallback Off forces the direct input to logic 0.
// - Hold-last-high keeps the last state while offline, logic 1 if never received.
// - Hold-last-low keeps the last state while offline, logic 0 if never received.
// - When the source comes back, hold-last inputs follow every received update again.
// - A peer message goes out at power-up and at once on any point change.
// - Each message restarts its source's live timer; expiry marks that source offline.
`default_nettype none

package pmlr_pkg;

    localparam int NUM_POINTS = 32;
    localparam int NUM_OPERANDS = 64;
    localparam int OPSEL_W = 6;
    localparam int NUM_DEV = 16;
    localparam int DEV_W = 4;
    localparam int BIT_W = 5;
    localparam int NUM_LATCH = 16;
    localparam int TTL_W = 16;
    localparam int ADDR_W = 12;

    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_TICK_CYCLES_DFLT = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MS_PER_SECOND = 1000;

    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] GOOSE_TAG_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] RESET_CMD_OFS = 12'h008;
    localparam logic [ADDR_W-1:0] RESET_OPSEL_OFS = 12'h00C;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h010;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 12'h014;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 12'h018;
    localparam logic [ADDR_W-1:0] LATCH_STATE_OFS = 12'h01C;
    localparam logic [ADDR_W-1:0] DEV_ONLINE_OFS = 12'h020;
    localparam logic [ADDR_W-1:0] DIN_STATE_OFS = 12'h024;
    localparam logic [ADDR_W-1:0] PEER_SEL_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] DOUT_SEL_BASE = 12'h180;
    localparam logic [ADDR_W-1:0] DIN_CFG_BASE = 12'h200;

    localparam int CTRL_XPORT_LSB = 0;
    localparam int CTRL_REFRESH_LSB = 8;
    localparam int GOOSE_VLAN_LSB = 0;
    localparam int GOOSE_APPID_LSB = 16;
    localparam int DIN_DEV_LSB = 0;
    localparam int DIN_BIT_LSB = 8;
    localparam int DIN_MODE_LSB = 16;
    localparam int IRQ_RESET_BIT = 0;
    localparam int IRQ_SENT_BIT = 1;
    localparam int IRQ_LOST_BIT = 2;
    localparam int IRQ_W = 3;

    localparam logic [5:0] REFRESH_MIN_S = 6'h01;
    localparam logic [5:0] REFRESH_MAX_S = 6'h3C;
    localparam logic [5:0] REFRESH_RST_S = 6'h3C;

    typedef enum logic [1:0] {
        PMLR_XPORT_NONE = 2'h0,
        PMLR_XPORT_GOOSE = 2'h1,
        PMLR_XPORT_GSSE = 2'h2
    } pmlr_xport_t;

    localparam pmlr_xport_t XPORT_RST = PMLR_XPORT_GSSE;

    typedef enum logic [1:0] {
        PMLR_DIN_OFF = 2'h0,
        PMLR_DIN_ON = 2'h1,
        PMLR_DIN_LAST_LOW = 2'h2,
        PMLR_DIN_LAST_HIGH = 2'h3
    } pmlr_din_mode_t;

    typedef struct packed {
        logic [DEV_W-1:0] device;
        logic [BIT_W-1:0] bitnum;
        pmlr_din_mode_t mode;
    } pmlr_din_cfg_t;

    localparam pmlr_din_cfg_t DIN_CFG_RST = '{device: 4'h0, bitnum: 5'h00, mode: PMLR_DIN_OFF};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } pmlr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pmlr_apb_rsp_t;

    typedef struct packed {
        logic valid;
        logic [DEV_W-1:0] device;
        logic [NUM_POINTS-1:0] bits;
        logic [TTL_W-1:0] ttl_ms;
    } pmlr_rx_msg_t;

endpackage : pmlr_pkg

`default_nettype wire

// [src/pmlr_peer_rx.sv]
`default_nettype none

// Per-source receive state: last bits, whether anything was ever heard, and the live timer.
module pmlr_peer_rx (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire pmlr_pkg::pmlr_rx_msg_t msg_i,
    input wire logic ms_tick_i,
    output logic [pmlr_pkg::NUM_DEV-1:0][pmlr_pkg::NUM_POINTS-1:0] bits_o,
    output logic [pmlr_pkg::NUM_DEV-1:0] online_o,
    output logic [pmlr_pkg::NUM_DEV-1:0] known_o,
    output logic [pmlr_pkg::NUM_DEV-1:0] lost_o
);
    import pmlr_pkg::*;

    typedef struct packed {
        logic [NUM_DEV-1:0][NUM_POINTS-1:0] bits;
        logic [NUM_DEV-1:0][TTL_W-1:0] timer;
        logic [NUM_DEV-1:0] online;
        logic [NUM_DEV-1:0] known;
        logic [NUM_DEV-1:0] lost;
    } pmlr_rx_state_t;

    pmlr_rx_state_t s;
    pmlr_rx_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.lost = '0;
        for (int d = 0; d < NUM_DEV; d++) begin
            if (msg_i.valid && msg_i.device == DEV_W'(d)) begin
                next_s.bits[d] = msg_i.bits;
                next_s.known[d] = 1'b1;
                next_s.timer[d] = msg_i.ttl_ms;
                next_s.online[d] = (msg_i.ttl_ms != '0);
            end else if (ms_tick_i && s.online[d]) begin
                next_s.timer[d] = s.timer[d] - 1'b1;
                if (s.timer[d] <= TTL_W'(1)) begin
                    next_s.online[d] = 1'b0;
                    next_s.lost[d] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bits_o = s.bits;
    assign online_o = s.online;
    assign known_o = s.known;
    assign lost_o = s.lost;

endmodule : pmlr_peer_rx

`default_nettype wire

// [src/pmlr_top.sv]
`default_nettype none

module pmlr_top #(
    parameter int MS_TICK_CYCLES = pmlr_pkg::MS_TICK_CYCLES_DFLT,
    parameter int MS_PER_S = pmlr_pkg::MS_PER_SECOND
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire pmlr_pkg::pmlr_apb_req_t apb_req_i,
    output pmlr_pkg::pmlr_apb_rsp_t apb_rsp_o,
    input wire logic [pmlr_pkg::NUM_OPERANDS-1:0] operands_i,
    input wire logic [pmlr_pkg::NUM_LATCH-1:0] latch_cond_i,
    input wire logic panel_button_i,
    input wire pmlr_pkg::pmlr_rx_msg_t rx_msg_i,
    output logic [pmlr_pkg::NUM_POINTS-1:0] peer_points_o,
    output logic peer_send_o,
    output pmlr_pkg::pmlr_xport_t peer_transport_select_o,
    output logic goose_tag_valid_o,
    output logic [11:0] goose_vlan_o,
    output logic [15:0] goose_appid_o,
    output logic [pmlr_pkg::NUM_POINTS-1:0] direct_out_o,
    output logic [pmlr_pkg::NUM_POINTS-1:0] direct_in_o,
    output logic [pmlr_pkg::NUM_DEV-1:0] dev_online_o,
    output logic [pmlr_pkg::NUM_LATCH-1:0] latched_o,
    output logic reset_any_source_o,
    output logic reset_from_panel_button_o,
    output logic reset_from_comms_o,
    output logic reset_from_selected_operand_o,
    output logic irq_o
);
    import pmlr_pkg::*;

    localparam int MS_W = $clog2(MS_TICK_CYCLES);
    localparam int MSS_W = $clog2(MS_PER_S);

    if (MS_TICK_CYCLES < 2 || MS_PER_S < 2) begin : g_bad_tick
        $error("Tick counts must be at least 2.");
    end

    typedef struct packed {
        pmlr_apb_rsp_t rsp;
        pmlr_xport_t xport;
        logic [5:0] refresh_s;
        logic [11:0] vlan;
        logic [15:0] appid;
        logic tag_valid;
        logic [OPSEL_W-1:0] reset_opsel;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        logic [NUM_POINTS-1:0][OPSEL_W-1:0] peer_sel;
        logic [NUM_POINTS-1:0][OPSEL_W-1:0] dout_sel;
        pmlr_din_cfg_t [NUM_POINTS-1:0] din_cfg;
        logic [NUM_POINTS-1:0] peer_points;
        logic peer_send;
        logic powerup_pending;
        logic [MS_W-1:0] ms_cnt;
        logic ms_tick;
        logic [MSS_W-1:0] ms_in_s;
        logic [5:0] sec_cnt;
        logic [NUM_POINTS-1:0] dout;
        logic [NUM_POINTS-1:0] din;
        logic [NUM_DEV-1:0] online;
        logic [NUM_LATCH-1:0] latched;
        logic [1:0] btn_sync;
        logic btn_prev;
        logic op_prev;
        logic rst_any;
        logic rst_btn;
        logic rst_comms;
        logic rst_op;
    } pmlr_state_t;

    pmlr_state_t s;
    pmlr_state_t next_s;

    logic [NUM_DEV-1:0][NUM_POINTS-1:0] rx_bits;
    logic [NUM_DEV-1:0] rx_online;
    logic [NUM_DEV-1:0] rx_known;
    logic [NUM_DEV-1:0] rx_lost;

    pmlr_peer_rx u_peer_rx (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .msg_i(rx_msg_i),
        .ms_tick_i(s.ms_tick),
        .bits_o(rx_bits),
        .online_o(rx_online),
        .known_o(rx_known),
        .lost_o(rx_lost)
    );

    // Array registers sit in 32-word windows; the index is the word within the window.
    function automatic logic in_window(input logic [ADDR_W-1:0] addr,
                                       input logic [ADDR_W-1:0] base);
        return addr[ADDR_W-1:7] == base[ADDR_W-1:7];
    endfunction : in_window

    function automatic logic [31:0] sel_word(input logic [OPSEL_W-1:0] sel);
        return {{(32-OPSEL_W){1'b0}}, sel};
    endfunction : sel_word

    always_comb begin
        logic setup;
        logic commit;
        logic [4:0] idx;
        logic [31:0] wd;
        logic [31:0] rd;
        logic mapped;
        logic sec_tick;
        logic refresh_due;
        logic changed;
        logic send_req;
        logic btn_edge;
        logic op_now;
        logic op_edge;
        logic [IRQ_W-1:0] ev;
        pmlr_din_cfg_t cfg;
        logic rx_bit;
        next_s = s;
        setup = apb_req_i.psel && !apb_req_i.penable;
        commit = apb_req_i.psel && apb_req_i.penable && s.rsp.pready;
        idx = apb_req_i.paddr[6:2];
        wd = apb_req_i.pwdata;
        rd = 32'h0000_0000;
        mapped = 1'b1;
        sec_tick = 1'b0;
        ev = '0;
        changed = 1'b0;
        refresh_due = 1'b0;
        send_req = 1'b0;
        btn_edge = 1'b0;
        op_now = 1'b0;
        op_edge = 1'b0;
        cfg = '0;
        rx_bit = 1'b0;

        // Read data is prepared during setup so that it comes straight from a flop.
        unique case (1'b1)
            apb_req_i.paddr == CTRL_OFS: begin
                rd[CTRL_XPORT_LSB +: 2] = s.xport;
                rd[CTRL_REFRESH_LSB +: 6] = s.refresh_s;
            end
            apb_req_i.paddr == GOOSE_TAG_OFS: begin
                rd[GOOSE_VLAN_LSB +: 12] = s.vlan;
                rd[GOOSE_APPID_LSB +: 16] = s.appid;
            end
            apb_req_i.paddr == RESET_CMD_OFS: rd = 32'h0000_0000;
            apb_req_i.paddr == RESET_OPSEL_OFS: rd = sel_word(s.reset_opsel);
            apb_req_i.paddr == IRQ_STATUS_OFS: rd[IRQ_W-1:0] = s.irq_stat;
            apb_req_i.paddr == IRQ_CLEAR_OFS: rd = 32'h0000_0000;
            apb_req_i.paddr == IRQ_ENABLE_OFS: rd[IRQ_W-1:0] = s.irq_en;
            apb_req_i.paddr == LATCH_STATE_OFS: rd[NUM_LATCH-1:0] = s.latched;
            apb_req_i.paddr == DEV_ONLINE_OFS: rd[NUM_DEV-1:0] = s.online;
            apb_req_i.paddr == DIN_STATE_OFS: rd = s.din;
            in_window(apb_req_i.paddr, PEER_SEL_BASE): rd = sel_word(s.peer_sel[idx]);
            in_window(apb_req_i.paddr, DOUT_SEL_BASE): rd = sel_word(s.dout_sel[idx]);
            in_window(apb_req_i.paddr, DIN_CFG_BASE): begin
                rd[DIN_DEV_LSB +: DEV_W] = s.din_cfg[idx].device;
                rd[DIN_BIT_LSB +: BIT_W] = s.din_cfg[idx].bitnum;
                rd[DIN_MODE_LSB +: 2] = s.din_cfg[idx].mode;
            end
            default: mapped = 1'b0;
        endcase
        if (apb_req_i.paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end

        next_s.rsp.pready = setup;
        next_s.rsp.pslverr = setup && !mapped;
        if (setup) begin
            next_s.rsp.prdata = mapped ? rd : 32'h0000_0000;
        end

        if (commit && apb_req_i.pwrite && !s.rsp.pslverr) begin
            unique case (1'b1)
                apb_req_i.paddr == CTRL_OFS: begin
                    if (wd[CTRL_XPORT_LSB +: 2] != 2'h3) begin
                        next_s.xport = pmlr_xport_t'(wd[CTRL_XPORT_LSB +: 2]);
                    end
                    // Out of range intervals are ignored rather than clamped.
                    if (wd[CTRL_REFRESH_LSB +: 6] >= REFRESH_MIN_S
                            && wd[CTRL_REFRESH_LSB +: 6] <= REFRESH_MAX_S) begin
                        next_s.refresh_s = wd[CTRL_REFRESH_LSB +: 6];
                    end
                end
                apb_req_i.paddr == GOOSE_TAG_OFS: begin
                    next_s.vlan = wd[GOOSE_VLAN_LSB +: 12];
                    next_s.appid = wd[GOOSE_APPID_LSB +: 16];
                end
                apb_req_i.paddr == RESET_CMD_OFS: next_s.rst_comms = wd[0];
                apb_req_i.paddr == RESET_OPSEL_OFS: next_s.reset_opsel = wd[OPSEL_W-1:0];
                apb_req_i.paddr == IRQ_CLEAR_OFS: next_s.irq_stat = s.irq_stat & ~wd[IRQ_W-1:0];
                apb_req_i.paddr == IRQ_ENABLE_OFS: next_s.irq_en = wd[IRQ_W-1:0];
                in_window(apb_req_i.paddr, PEER_SEL_BASE): begin
                    next_s.peer_sel[idx] = wd[OPSEL_W-1:0];
                end
                in_window(apb_req_i.paddr, DOUT_SEL_BASE): begin
                    next_s.dout_sel[idx] = wd[OPSEL_W-1:0];
                end
                in_window(apb_req_i.paddr, DIN_CFG_BASE): begin
                    next_s.din_cfg[idx].device = wd[DIN_DEV_LSB +: DEV_W];
                    next_s.din_cfg[idx].bitnum = wd[DIN_BIT_LSB +: BIT_W];
                    next_s.din_cfg[idx].mode = pmlr_din_mode_t'(wd[DIN_MODE_LSB +: 2]);
                end
                default: ;
            endcase
        end
        if (!(commit && apb_req_i.pwrite && apb_req_i.paddr == RESET_CMD_OFS)) begin
            next_s.rst_comms = 1'b0;
        end

        // Millisecond and second time base.
        next_s.ms_tick = 1'b0;
        if (s.ms_cnt == MS_W'(MS_TICK_CYCLES - 1)) begin
            next_s.ms_cnt = '0;
            next_s.ms_tick = 1'b1;
        end else begin
            next_s.ms_cnt = s.ms_cnt + 1'b1;
        end
        if (s.ms_tick) begin
            if (s.ms_in_s == MSS_W'(MS_PER_S - 1)) begin
                next_s.ms_in_s = '0;
                sec_tick = 1'b1;
            end else begin
                next_s.ms_in_s = s.ms_in_s + 1'b1;
            end
        end

        for (int i = 0; i < NUM_POINTS; i++) begin
            next_s.peer_points[i] = operands_i[s.peer_sel[i]];
            next_s.dout[i] = operands_i[s.dout_sel[i]];
        end
        changed = next_s.peer_points != s.peer_points;
        refresh_due = sec_tick && (s.sec_cnt + 6'h01 >= s.refresh_s);
        send_req = s.powerup_pending || changed || refresh_due;
        next_s.peer_send = send_req && next_s.xport != PMLR_XPORT_NONE;
        next_s.powerup_pending = 1'b0;
        if (send_req) begin
            next_s.sec_cnt = '0;
        end else if (sec_tick) begin
            next_s.sec_cnt = s.sec_cnt + 6'h01;
        end
        next_s.tag_valid = next_s.xport == PMLR_XPORT_GOOSE;

        // Direct inputs resolve from the receive state of their source device.
        next_s.online = rx_online;
        for (int i = 0; i < NUM_POINTS; i++) begin
            cfg = s.din_cfg[i];
            rx_bit = rx_bits[cfg.device][cfg.bitnum];
            if (rx_online[cfg.device]) begin
                next_s.din[i] = rx_bit;
            end else begin
                unique case (cfg.mode)
                    PMLR_DIN_ON: next_s.din[i] = 1'b1;
                    PMLR_DIN_OFF: next_s.din[i] = 1'b0;
                    PMLR_DIN_LAST_HIGH: next_s.din[i] = rx_known[cfg.device] ? rx_bit : 1'b1;
                    PMLR_DIN_LAST_LOW: next_s.din[i] = rx_known[cfg.device] ? rx_bit : 1'b0;
                endcase
            end
        end

        // The panel button is a pin, so only the second synchroniser stage is inspected.
        next_s.btn_sync = {s.btn_sync[0], panel_button_i};
        next_s.btn_prev = s.btn_sync[1];
        btn_edge = s.btn_sync[1] && !s.btn_prev;
        op_now = operands_i[s.reset_opsel];
        next_s.op_prev = op_now;
        op_edge = op_now && !s.op_prev;
        next_s.rst_btn = btn_edge;
        next_s.rst_op = op_edge;
        next_s.rst_any = btn_edge || op_edge || next_s.rst_comms;

        // Only indicator latches live here; user programmable latches are out of reach.
        // A reset with the condition still present leaves the latch set.
        next_s.latched = s.latched | latch_cond_i;
        if (next_s.rst_any) begin
            next_s.latched = latch_cond_i;
        end

        ev[IRQ_RESET_BIT] = next_s.rst_any;
        ev[IRQ_SENT_BIT] = next_s.peer_send;
        ev[IRQ_LOST_BIT] = |rx_lost;
        // Setting after the clear lets an event in the clearing cycle survive.
        next_s.irq_stat = next_s.irq_stat | ev;
        next_s.irq = |(next_s.irq_stat & next_s.irq_en);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s <= '0;
            s.xport <= XPORT_RST;
            s.refresh_s <= REFRESH_RST_S;
            s.powerup_pending <= 1'b1;
            s.din_cfg <= {NUM_POINTS{DIN_CFG_RST}};
        end else begin
            s <= next_s;
        end
    end

    assign apb_rsp_o = s.rsp;
    assign peer_points_o = s.peer_points;
    assign peer_send_o = s.peer_send;
    assign peer_transport_select_o = s.xport;
    assign goose_tag_valid_o = s.tag_valid;
    assign goose_vlan_o = s.vlan;
    assign goose_appid_o = s.appid;
    assign direct_out_o = s.dout;
    assign direct_in_o = s.din;
    assign dev_online_o = s.online;
    assign latched_o = s.latched;
    assign reset_any_source_o = s.rst_any;
    assign reset_from_panel_button_o = s.rst_btn;
    assign reset_from_comms_o = s.rst_comms;
    assign reset_from_selected_operand_o = s.rst_op;
    assign irq_o = s.irq;

endmodule : pmlr_top

`default_nettype wire

// [dv/pmlr_properties.sv]
`default_nettype none

module pmlr_properties import pmlr_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic panel_button_i,
    input wire logic [NUM_LATCH-1:0] latch_cond_i,
    input wire logic [NUM_POINTS-1:0] peer_points_o,
    input wire logic peer_send_o,
    input wire pmlr_xport_t peer_transport_select_o,
    input wire logic goose_tag_valid_o,
    input wire logic [NUM_LATCH-1:0] latched_o,
    input wire logic reset_any_source_o,
    input wire logic reset_from_panel_button_o,
    input wire logic reset_from_comms_o,
    input wire logic reset_from_selected_operand_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    logic src;
    assign src = reset_from_panel_button_o | reset_from_comms_o | reset_from_selected_operand_o;

    // A press is held up for two samples here, though one sample already gets past the synchroniser.
    sequence press_s;
        $rose(panel_button_i) ##1 panel_button_i;
    endsequence

    chk_src_any: assert property (src |-> reset_any_source_o)
        else $error("source reset without common reset");
    chk_any_src: assert property (reset_any_source_o |-> src)
        else $error("common reset without a source");
    chk_pulse_one: assert property (reset_any_source_o |=> !reset_any_source_o)
        else $error("common reset longer than one cycle");
    chk_button_path: assert property (press_s |-> ##[1:3] reset_from_panel_button_o)
        else $error("button press gave no reset");
    chk_latch_fall: assert property (|($past(latched_o) & ~latched_o) |-> reset_any_source_o)
        else $error("latch cleared without reset");
    chk_latch_keep: assert property (reset_any_source_o |->
        &(latched_o | ~($past(latched_o) & $past(latch_cond_i))))
        else $error("latch with active condition cleared");
    chk_send_change: assert property ($changed(peer_points_o) &&
        peer_transport_select_o != PMLR_XPORT_NONE |-> peer_send_o)
        else $error("point change not sent");
    chk_none_quiet: assert property (peer_transport_select_o == PMLR_XPORT_NONE |-> !peer_send_o)
        else $error("send with no transport");
    chk_goose_flag: assert property (goose_tag_valid_o ==
        (peer_transport_select_o == PMLR_XPORT_GOOSE))
        else $error("tag valid disagrees with transport");
endmodule : pmlr_properties

bind pmlr_top pmlr_properties u_pmlr_properties (.ref_clk_i, .reset_i, .panel_button_i,
    .latch_cond_i, .peer_points_o, .peer_send_o, .peer_transport_select_o, .goose_tag_valid_o,
    .latched_o, .reset_any_source_o, .reset_from_panel_button_o, .reset_from_comms_o,
    .reset_from_selected_operand_o);

`default_nettype wire

// [dv/pmlr_peer_model.sv]
`default_nettype none

module pmlr_peer_model import pmlr_pkg::*; (
    input wire logic ref_clk_i,
    output var pmlr_rx_msg_t rx_msg_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial rx_msg_o = '0;

    task automatic send(input logic [3:0] dev, input logic [31:0] bits, input logic [15:0] ttl);
        @(posedge ref_clk_i);
        rx_msg_o <= '{valid: 1'b1, device: dev, bits: bits, ttl_ms: ttl};
        @(posedge ref_clk_i);
        // Outside a message the fields carry junk, so a stale capture cannot look right.
        rx_msg_o <= '{valid: 1'b0, device: ~dev, bits: ~bits, ttl_ms: ~ttl};
    endtask : send
endmodule : pmlr_peer_model

`default_nettype wire

// [dv/test_peer_signal_mapping_latch_reset.sv]
`default_nettype none
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin fail_count++; \
    $display("ERROR %0t: got %h want %h", $time, act, exp); end end

module test_peer_signal_mapping_latch_reset;
    timeunit 1ns;
    timeprecision 1ns;
    import pmlr_pkg::*;

    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    pmlr_apb_req_t req = '0;
    pmlr_apb_rsp_t rsp;
    logic [63:0] ops = '0;
    logic [15:0] cond = '0;
    logic btn = 1'b0;
    pmlr_rx_msg_t rx;
    pmlr_xport_t xp;
    logic [31:0] pts, dout, ep, ed, din;
    logic [15:0] lat, onl, appid;
    logic [11:0] vlan;
    logic send, tagv, irq, r_any, r_pan, r_com, r_op;
    logic [4:0] pul;
    logic [15:0] seed = 16'h004C;
    logic [32:0] exp_q[$];
    logic [32:0] got_e;
    int fail_count = 0;
    int cmp_count = 0;
    int cnt[5] = '{default: 0};
    int base[5];

    always #20 ref_clk_i = ~ref_clk_i;

    pmlr_top #(.MS_TICK_CYCLES(4), .MS_PER_S(4)) u_pmlr_top (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .apb_req_i(req), .apb_rsp_o(rsp), .operands_i(ops),
        .latch_cond_i(cond), .panel_button_i(btn), .rx_msg_i(rx), .peer_points_o(pts),
        .peer_send_o(send), .peer_transport_select_o(xp), .goose_tag_valid_o(tagv),
        .goose_vlan_o(vlan), .goose_appid_o(appid), .direct_out_o(dout), .direct_in_o(din),
        .dev_online_o(onl), .latched_o(lat), .reset_any_source_o(r_any),
        .reset_from_panel_button_o(r_pan), .reset_from_comms_o(r_com),
        .reset_from_selected_operand_o(r_op), .irq_o(irq));

    pmlr_peer_model u_pmlr_peer_model (.ref_clk_i(ref_clk_i), .rx_msg_o(rx));

    assign pul = {r_op, r_com, r_pan, r_any, send};

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge ref_clk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        if (!w) exp_q.push_back(e);
        @(posedge ref_clk_i);
        req.penable <= 1'b1;
        do @(posedge ref_clk_i); while (rsp.pready !== 1'b1);
        req <= '0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0, {1'b0, e});
    endtask : rd

    // Read data is judged apart from the driver, in issue order.
    always @(posedge ref_clk_i) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
            got_e = exp_q.pop_front();
            `CHK({rsp.pslverr, rsp.prdata}, got_e)
        end
        if (!reset_i) for (int k = 0; k < 5; k++) cnt[k] += (pul[k] === 1'b1);
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        `CHK(cnt[0], 1)
        rd(CTRL_OFS, 32'h0000_3C02);
        apb(1'b0, 12'h030, '0, {1'b1, 32'h0});
        for (int x = 0; x < 4; x++) begin
            wr(CTRL_OFS, 32'h0200 | 32'(x));
            rd(CTRL_OFS, 32'h0200 | 32'(x == 3 ? 2 : x));
        end
        wr(CTRL_OFS, 32'h3D02);
        rd(CTRL_OFS, 32'h0202);
        wr(GOOSE_TAG_OFS, 32'h5A5A_0A5A);
        for (int i = 0; i < 32; i++) begin
            wr(PEER_SEL_BASE + 12'(4 * i), 32'((5 * i + 3) % 64));
            wr(DOUT_SEL_BASE + 12'(4 * i), 32'((7 * i + 1) % 64));
        end
        `CHK({appid, vlan}, 28'h5A5A_A5A)
        repeat (8) begin
            @(posedge ref_clk_i);
            for (int k = 0; k < 4; k++) begin
                seed = lfsr(seed);
                ops[16 * k +: 16] <= seed;
            end
            repeat (3) @(posedge ref_clk_i);
            for (int i = 0; i < 32; i++) begin
                ep[i] = ops[(5 * i + 3) % 64];
                ed[i] = ops[(7 * i + 1) % 64];
            end
            `CHK(pts, ep)
            `CHK(dout, ed)
        end
        @(negedge ref_clk_i);
        base = cnt;
        repeat (96) @(negedge ref_clk_i);
        `CHK((cnt[0] - base[0]) inside {[2:6]}, 1'b1)
        wr(CTRL_OFS, 32'h0200);
        @(negedge ref_clk_i);
        base = cnt;
        repeat (96) @(negedge ref_clk_i);
        `CHK(cnt[0] - base[0], 0)
        wr(CTRL_OFS, 32'h3C02);
        for (int m = 0; m < 4; m++) wr(DIN_CFG_BASE + 12'(4 * m), 32'h0705 | 32'(m << 16));
        rd(DIN_STATE_OFS, 32'hA);
        u_pmlr_peer_model.send(4'h5, 32'hFFFF_FF7F, 16'd8);
        rd(DEV_ONLINE_OFS, 32'h20);
        `CHK(onl, 16'h0020)
        rd(DIN_STATE_OFS, 32'h0);
        repeat (50) @(posedge ref_clk_i);
        rd(DEV_ONLINE_OFS, 32'h0);
        rd(DIN_STATE_OFS, 32'h2);
        `CHK(irq, 1'b0)
        wr(IRQ_ENABLE_OFS, 32'h4);
        repeat (2) @(posedge ref_clk_i);
        `CHK(irq, 1'b1)
        wr(IRQ_CLEAR_OFS, 32'h4);
        repeat (2) @(posedge ref_clk_i);
        `CHK(irq, 1'b0)
        u_pmlr_peer_model.send(4'h5, 32'h0000_0080, 16'd8);
        rd(DIN_STATE_OFS, 32'hF);
        u_pmlr_peer_model.send(4'h5, 32'h0000_0080, 16'd0);
        rd(DIN_STATE_OFS, 32'hE);
        `CHK(din, 32'hE)
        @(posedge ref_clk_i);
        ops <= '0;
        cond <= 16'h0003;
        repeat (3) @(posedge ref_clk_i);
        cond <= 16'h0002;
        rd(LATCH_STATE_OFS, 32'h3);
        @(negedge ref_clk_i);
        base = cnt;
        wr(RESET_CMD_OFS, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        rd(LATCH_STATE_OFS, 32'h2);
        `CHK(lat, 16'h0002)
        wr(RESET_OPSEL_OFS, 32'hA);
        @(posedge ref_clk_i);
        ops[10] <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        ops[10] <= 1'b0;
        btn <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        btn <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        cond <= '0;
        wr(RESET_CMD_OFS, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        rd(LATCH_STATE_OFS, 32'h0);
        @(negedge ref_clk_i);
        `CHK(cnt[1] - base[1], 4)
        `CHK(cnt[2] - base[2], 1)
        `CHK(cnt[3] - base[3], 2)
        `CHK(cnt[4] - base[4], 1)
        finish_test();
    end
endmodule : test_peer_signal_mapping_latch_reset

`default_nettype wire
